// *** rtl/smr_mode4_regs.vh ***
/*
 holds the field positions, codes and reset values of the fourth mode
 register; assumes it is included once per design through its guard.
*/
`ifndef SMR_MODE4_REGS_VH
`define SMR_MODE4_REGS_VH
`define SMR_WIDTH 22
`define SMR_RESET 22'h000000
`define SMR_SEL_HI 20
`define SMR_SEL_LO 18
`define SMR_SEL_THIS 3'h4
`define SMR_SEL_DO_NOT_USE 3'h7
`define SMR_RSV_HI 21
`define SMR_RSV_MID 17
`define SMR_RSV_LO 0
`define SMR_HARD_REP 13
`define SMR_WR_PRE 12
`define SMR_RD_PRE 11
`define SMR_RD_TRAIN 10
`define SMR_SR_ABORT 9
`define SMR_CAL_HI 8
`define SMR_CAL_LO 6
`define SMR_SOFT_REP 5
`define SMR_VREF_MON 4
`define SMR_TCR_EN 3
`define SMR_TCR_RANGE 2
`define SMR_MAX_PWR 1
`define SMR_RDO_HARD 7
`define SMR_RDO_SOFT 6
`define SMR_CAL_0 3'h0
`define SMR_CAL_3 3'h1
`define SMR_CAL_4 3'h2
`define SMR_CAL_5 3'h3
`define SMR_CAL_6 3'h4
`define SMR_CAL_8 3'h5
`define SMR_CAL_RESET 4'h0
`define SMR_FLAG_RESET 1'b0
`define SMR_CLK_0 4'h0
`define SMR_CLK_3 4'h3
`define SMR_CLK_4 4'h4
`define SMR_CLK_5 4'h5
`define SMR_CLK_6 4'h6
`define SMR_CLK_8 4'h8
`endif

// *** rtl/smr_mode_register_four.v ***
/*
 holds the fourth mode register, decodes its fields, tracks gear-down
 entry, per-device masking, row repair bookkeeping and readout bits.
 assumes command pins are sampled on mclk, one command per cycle.
*/
`timescale 1ns/1ps
`include "smr_mode4_regs.vh"

// Contract
// - set command loads bits 21:0 from pins when select field is 100
// - bit 13 enables hard row repair
// - bit 12 picks one or two clock write preamble
// - bit 9 enables self refresh abort
// - bits 8:6 give command address latency 0,3,4,5,6,8; rest reserved
// - bit 5 enables soft row repair
// - bit 3 enables temperature controlled refresh
// - bit 2 selects normal or extended temperature range
// - bit 1 enters maximum power saving
// - comes up half rate; quarter rate needs set command then sync pulse
// - per-device addressing lets each device accept or ignore commands
// - readout page 2 location 0 bit 7 shows hard repair available
// - hard repair replaces one row per bank, permanently; here the per-bank used flags are cleared by reset
// - readout page 2 location 0 bit 6 shows soft repair available
module smr_mode_register_four #(
    parameter NBANKS = 16,
    parameter HARD_AVAIL = 1'b1,
    parameter SOFT_AVAIL = 1'b1
) (
    mclk,
    resetn,
    cmdValid,
    rowStrobeN,
    colStrobeN,
    writeEnN,
    cmdAddr,
    perDevEnable,
    devSelected,
    gearReqQuarter,
    syncPulse,
    repairBank,
    repairFire,
    modeReg,
    hardRepairEn,
    writePreTwo,
    readPreTwo,
    readPreTrain,
    srAbortEn,
    calClocks,
    calReserved,
    softRepairEn,
    vrefMonEn,
    tcrEn,
    tcrExtended,
    maxPowerSave,
    quarterRate,
    gearViolation,
    cmdAccepted,
    readoutPage2Loc0,
    hardRepairUsed,
    repairRefused
);
    input mclk;
    input resetn;
    input cmdValid;
    input rowStrobeN;
    input colStrobeN;
    input writeEnN;
    input [`SMR_WIDTH-1:0] cmdAddr;
    input perDevEnable;
    input devSelected;
    input gearReqQuarter;
    input syncPulse;
    input [3:0] repairBank;
    input repairFire;
    output [`SMR_WIDTH-1:0] modeReg;
    output hardRepairEn;
    output writePreTwo;
    output readPreTwo;
    output readPreTrain;
    output srAbortEn;
    output [3:0] calClocks;
    output calReserved;
    output softRepairEn;
    output vrefMonEn;
    output tcrEn;
    output tcrExtended;
    output maxPowerSave;
    output quarterRate;
    output gearViolation;
    output cmdAccepted;
    output [7:0] readoutPage2Loc0;
    output [NBANKS-1:0] hardRepairUsed;
    output repairRefused;

    wire mclk;
    wire resetn;
    wire cmdValid;
    wire rowStrobeN;
    wire colStrobeN;
    wire writeEnN;
    wire [`SMR_WIDTH-1:0] cmdAddr;
    wire perDevEnable;
    wire devSelected;
    wire gearReqQuarter;
    wire syncPulse;
    wire [3:0] repairBank;
    wire repairFire;
    wire [`SMR_WIDTH-1:0] modeReg;
    wire hardRepairEn;
    wire writePreTwo;
    wire readPreTwo;
    wire readPreTrain;
    wire srAbortEn;
    wire [3:0] calClocks;
    wire calReserved;
    wire softRepairEn;
    wire vrefMonEn;
    wire tcrEn;
    wire tcrExtended;
    wire maxPowerSave;
    wire quarterRate;
    wire gearViolation;
    wire cmdAccepted;
    wire [7:0] readoutPage2Loc0;
    wire [NBANKS-1:0] hardRepairUsed;
    wire repairRefused;

    reg [`SMR_WIDTH-1:0] mr_ff;
    reg [`SMR_WIDTH-1:0] nxt_mr;
    reg [3:0] cal_ff;
    reg [3:0] nxt_cal;
    reg [3:0] decodedCal;
    reg gearArm_ff;
    reg nxt_gearArm;
    reg quarter_ff;
    reg nxt_quarter;
    reg refused_ff;
    reg nxt_refused;
    reg [NBANKS-1:0] used_ff;
    wire [NBANKS-1:0] nxt_used;
    wire [NBANKS-1:0] bankHit;
    wire strobesLow;
    wire devAddressed;
    wire setCmd;
    wire selThis;
    wire hardArmed;
    wire bankUsed;
    wire calIsThree;
    wire calIsFive;
    wire shortPreamble;

    // strobes all low marks the set command
    assign strobesLow = ~rowStrobeN & ~colStrobeN & ~writeEnN;
    // a masked device must not even arm gear-down from a shared command
    assign devAddressed = ~perDevEnable | devSelected;
    assign setCmd = cmdValid & strobesLow & devAddressed;
    assign selThis = cmdAddr[`SMR_SEL_HI:`SMR_SEL_LO] == `SMR_SEL_THIS;
    assign cmdAccepted = setCmd & selThis;

    always @* begin
        decodedCal = `SMR_CLK_0;
        case (cmdAddr[`SMR_CAL_HI:`SMR_CAL_LO])
            `SMR_CAL_0: begin
                decodedCal = `SMR_CLK_0;
            end
            `SMR_CAL_3: begin
                decodedCal = `SMR_CLK_3;
            end
            `SMR_CAL_4: begin
                decodedCal = `SMR_CLK_4;
            end
            `SMR_CAL_5: begin
                decodedCal = `SMR_CLK_5;
            end
            `SMR_CAL_6: begin
                decodedCal = `SMR_CLK_6;
            end
            `SMR_CAL_8: begin
                decodedCal = `SMR_CLK_8;
            end
            default: begin
                // reserved codes leave the latency off rather than guess
                decodedCal = `SMR_CLK_0;
            end
        endcase
    end

    always @* begin
        nxt_mr = mr_ff;
        nxt_cal = cal_ff;
        if (cmdAccepted) begin
            // reserved bits are stored as written so mistakes stay visible
            nxt_mr = cmdAddr;
            nxt_cal = decodedCal;
        end
    end

    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            mr_ff <= `SMR_RESET;
            cal_ff <= `SMR_CAL_RESET;
        end else begin
            mr_ff <= nxt_mr;
            cal_ff <= nxt_cal;
        end
    end

    // gear-down: armed by any set command with gearReqQuarter high, taken on a later sync pulse
    always @* begin
        nxt_gearArm = gearArm_ff;
        if (setCmd) begin
            nxt_gearArm = gearReqQuarter;
        end else if (syncPulse) begin
            nxt_gearArm = 1'b0;
        end
    end

    // a sync pulse alongside a set command is ignored; only reset exits
    always @* begin
        nxt_quarter = quarter_ff;
        if (syncPulse && gearArm_ff && !setCmd) begin
            nxt_quarter = 1'b1;
        end
    end

    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            gearArm_ff <= `SMR_FLAG_RESET;
            quarter_ff <= `SMR_FLAG_RESET;
        end else begin
            gearArm_ff <= nxt_gearArm;
            quarter_ff <= nxt_quarter;
        end
    end

    assign hardArmed = mr_ff[`SMR_HARD_REP];
    // one-hot bank decode keeps the per-bank compare free of width games
    assign bankHit = {{(NBANKS-1){1'b0}}, 1'b1} << repairBank;
    assign bankUsed = used_ff[repairBank];

    genvar gb;
    generate
        for (gb = 0; gb < NBANKS; gb = gb + 1) begin : bankLoop
            // only reset clears a used bank: the repair is meant to be permanent
            assign nxt_used[gb] = used_ff[gb]
                | (repairFire & hardArmed & bankHit[gb]);
            always @(posedge mclk or negedge resetn) begin
                if (!resetn) begin
                    used_ff[gb] <= `SMR_FLAG_RESET;
                end else begin
                    used_ff[gb] <= nxt_used[gb];
                end
            end
        end
    endgenerate

    always @* begin
        nxt_refused = 1'b0;
        if (repairFire && hardArmed && bankUsed) begin
            nxt_refused = 1'b1;
        end
    end

    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            refused_ff <= `SMR_FLAG_RESET;
        end else begin
            refused_ff <= nxt_refused;
        end
    end

    assign modeReg = mr_ff;
    assign hardRepairEn = mr_ff[`SMR_HARD_REP];
    assign writePreTwo = mr_ff[`SMR_WR_PRE];
    assign readPreTwo = mr_ff[`SMR_RD_PRE];
    assign readPreTrain = mr_ff[`SMR_RD_TRAIN];
    assign srAbortEn = mr_ff[`SMR_SR_ABORT];
    assign calClocks = cal_ff;
    assign calReserved = mr_ff[`SMR_CAL_HI] & mr_ff[`SMR_CAL_HI-1];
    assign softRepairEn = mr_ff[`SMR_SOFT_REP];
    assign vrefMonEn = mr_ff[`SMR_VREF_MON];
    assign tcrEn = mr_ff[`SMR_TCR_EN];
    assign tcrExtended = mr_ff[`SMR_TCR_RANGE];
    assign maxPowerSave = mr_ff[`SMR_MAX_PWR];
    assign quarterRate = quarter_ff;

    assign calIsThree = cal_ff == `SMR_CLK_3;
    assign calIsFive = cal_ff == `SMR_CLK_5;
    assign shortPreamble = ~mr_ff[`SMR_WR_PRE] | ~mr_ff[`SMR_RD_PRE];
    // flag only; the device keeps the setting the controller chose
    assign gearViolation = quarter_ff
        & (calIsThree | calIsFive | shortPreamble);
    assign readoutPage2Loc0 = {HARD_AVAIL[0], SOFT_AVAIL[0],
        6'h00};
    assign hardRepairUsed = used_ff;
    assign repairRefused = refused_ff;
endmodule

// *** tb/smr_mode4_props.sv ***
/* assertions on the fourth mode register ports;
   bound to the design top, single mclk domain */
`timescale 1ns/1ps
module smr_mode4_props(
    input wire mclk,
    input wire resetn,
    input wire cmdValid,
    input wire rowStrobeN,
    input wire colStrobeN,
    input wire writeEnN,
    input wire [21:0] cmdAddr,
    input wire [21:0] modeReg,
    input wire [3:0] calClocks,
    input wire calReserved,
    input wire maxPowerSave,
    input wire quarterRate,
    input wire syncPulse,
    input wire cmdAccepted,
    input wire [7:0] readoutPage2Loc0
);
default clocking cb @(posedge mclk); endclocking
default disable iff (!resetn);
a_load_word: assert property (cmdAccepted |=> modeReg == $past(cmdAddr))
    else $error("word not loaded");
a_hold_word: assert property (!cmdAccepted |=> $stable(modeReg))
    else $error("word changed");
a_accept_cond: assert property (cmdAccepted |-> cmdValid &&
    !(rowStrobeN | colStrobeN | writeEnN) && cmdAddr[20:18] == 3'h4)
    else $error("bad accept");
a_cal_decode: assert property (calClocks == (modeReg[8:6] == 3'h5 ? 4'h8 :
    (modeReg[8:6] == 3'h0 || modeReg[8:6] > 3'h5) ? 4'h0 :
    {1'b0, modeReg[8:6]} + 4'h2)) else $error("latency");
a_cal_reserved: assert property (calReserved == (modeReg[8:7] == 2'h3))
    else $error("reserved code");
a_gear_sync: assert property ($rose(quarterRate) |-> $past(syncPulse))
    else $error("gear without sync");
a_power_bit: assert property (maxPowerSave == modeReg[1])
    else $error("power bit");
a_readout_bits: assert property (readoutPage2Loc0 == 8'hC0)
    else $error("readout");
endmodule
bind smr_mode_register_four smr_mode4_props chk(.mclk, .resetn, .cmdValid,
    .rowStrobeN, .colStrobeN, .writeEnN, .cmdAddr, .modeReg, .calClocks,
    .calReserved, .maxPowerSave, .quarterRate, .syncPulse, .cmdAccepted,
    .readoutPage2Loc0);

// *** tb/smr_ctrl_model.sv ***
/* controller model driving the command pins at falling edges;
   assumes the device samples on rising mclk */
`timescale 1ns/1ps
module smr_ctrl_model(
    input wire mclk,
    output reg cmdValid,
    output reg rowStrobeN,
    output reg colStrobeN,
    output reg writeEnN,
    output reg [21:0] cmdAddr,
    output reg gearReqQuarter
);
// lowest write latency the model assumes for its clock period
parameter [4:0] WR_LAT_MIN = 5'h09;
reg [4:0] writeLatencySetting;
initial begin
    cmdValid = 1'b0;
    {rowStrobeN, colStrobeN, writeEnN} = 3'h7;
    cmdAddr = 22'h0;
    gearReqQuarter = 1'b0;
    writeLatencySetting = WR_LAT_MIN;
end
task issue(input [21:0] a, input q, input s);
begin
    @(negedge mclk);
    // two clock write preamble goes with a latency one above minimum
    writeLatencySetting = WR_LAT_MIN + {4'h0, a[12]};
    cmdValid = 1'b1;
    {rowStrobeN, colStrobeN, writeEnN} = s ? 3'h0 : 3'h5;
    cmdAddr = a & 22'h1DFFFE;
    gearReqQuarter = q;
    @(negedge mclk);
    cmdValid = 1'b0;
    {rowStrobeN, colStrobeN, writeEnN} = 3'h7;
    cmdAddr = ~cmdAddr; // idle pins must not echo the last word
    gearReqQuarter = 1'b0;
end
endtask
endmodule

// *** tb/smr_mode_register_four_tb.sv ***
/* self-checking bench for the fourth mode register;
   assumes the controller model and the bound checker */
`timescale 1ns/1ps
module smr_mode_register_four_tb;
reg mclk = 0, resetn = 0, perDevEnable = 0, devSelected = 1;
reg syncPulse = 0, repairFire = 0;
reg [3:0] repairBank = 4'h5;
wire cmdValid, rowStrobeN, colStrobeN, writeEnN, gearReqQuarter;
wire quarterRate, gearViolation, repairRefused;
wire [21:0] cmdAddr, modeReg;
wire [9:0] flags;
wire [3:0] calClocks;
wire [7:0] readout;
wire [15:0] used;
integer fails = 0, check_count = 0, cyc = 0, i, seed = 32'h8FA5208F;
reg [21:0] a, e;
reg [31:0] rnd;
smr_ctrl_model ctl(.mclk, .cmdValid, .rowStrobeN, .colStrobeN, .writeEnN,
    .cmdAddr, .gearReqQuarter);
smr_mode_register_four dut(.mclk, .resetn, .cmdValid, .rowStrobeN,
    .colStrobeN, .writeEnN, .cmdAddr, .perDevEnable, .devSelected,
    .gearReqQuarter, .syncPulse, .repairBank, .repairFire, .modeReg,
    .hardRepairEn(flags[9]), .writePreTwo(flags[8]), .readPreTwo(flags[7]),
    .readPreTrain(flags[6]), .srAbortEn(flags[5]), .calClocks,
    .calReserved(), .softRepairEn(flags[4]), .vrefMonEn(flags[3]),
    .tcrEn(flags[2]), .tcrExtended(flags[1]), .maxPowerSave(flags[0]),
    .quarterRate, .gearViolation, .cmdAccepted(),
    .readoutPage2Loc0(readout), .hardRepairUsed(used), .repairRefused);
initial forever #20 mclk = ~mclk;
always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
        fails = fails + 1;
        stop_test;
    end
end
function [3:0] calf(input [2:0] c);
    calf = c == 3'h5 ? 4'h8 : (c == 3'h0 || c > 3'h5) ? 4'h0 : c + 4'h2;
endfunction
task chk(input [31:0] s, input [31:0] x, input [63:0] n);
begin
    check_count = check_count + 1;
    if (s !== x) begin
        fails = fails + 1;
        $display("unexpected %0s exp %h saw %h", n, x, s);
    end
end
endtask
task stop_test;
begin
    if (fails == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
end
endtask
task pulse_sync;
begin
    @(negedge mclk);
    syncPulse = 1'b1;
    @(negedge mclk);
    syncPulse = 1'b0;
end
endtask
initial begin
    repeat (3) @(negedge mclk);
    chk({quarterRate, modeReg}, 0, "reset");
    resetn = 1;
    for (i = 0; i < 24; i = i + 1) begin
        rnd = $random(seed);
        a = rnd[21:0];
        a[20:18] = 3'h4;
        a[8:6] = i[2:0];
        e = a & 22'h1DFFFE;
        ctl.issue(a, 1'b0, 1'b1);
        chk(modeReg, e, "word");
        chk(calClocks, calf(e[8:6]), "latency");
        chk(flags, {e[13:9], e[5:1]}, "fields");
    end
    // unknown select, row and write strobes high, masked device: all must be ignored
    for (i = 0; i < 3; i = i + 1) begin
        perDevEnable = i == 2;
        devSelected = i != 2;
        ctl.issue(i == 0 ? 22'h1C0000 : 22'h10FFFE, 1'b0, i != 1);
        chk(modeReg, e, "refused");
    end
    // sync with nothing armed must leave the device at half rate
    pulse_sync;
    chk(quarterRate, 0, "halfrate");
    perDevEnable = 0;
    devSelected = 1;
    ctl.issue(22'h102000, 1'b1, 1'b1);
    for (i = 0; i < 2; i = i + 1) begin
        @(negedge mclk);
        repairFire = 1;
        @(negedge mclk);
        repairFire = 0;
        chk({used, repairRefused}, {16'h0020, i[0]}, "repair");
    end
    pulse_sync;
    chk({quarterRate, gearViolation}, 2'h3, "gear");
    chk(readout, 8'hC0, "readout");
    // mid-run reset is the only way back to half rate
    @(negedge mclk);
    resetn = 0;
    @(negedge mclk);
    chk({quarterRate, modeReg}, 0, "reset2");
    resetn = 1;
    ctl.issue(22'h101E1E, 1'b0, 1'b1);
    chk(modeReg, 22'h101E1E, "word2");
    stop_test;
end
endmodule
